// >>> src/eid_pkg.sv
`default_nettype none
package eid_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_WREG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FSR0 = 8'h0c;
  localparam logic [7:0] REG_FSR1 = 8'h10;
  localparam logic [7:0] REG_PC = 8'h14;
  localparam logic [7:0] REG_OPTION = 8'h18;
  localparam logic [7:0] REG_PINDIR = 8'h1c;
  localparam logic [7:0] REG_FADDR = 8'h20;
  localparam logic [7:0] REG_FDATA = 8'h24;

  // Status register bit positions.
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_GIE = 5;
  localparam int ST_BUSY = 6;

  // Fixed instruction words.
  localparam logic [13:0] W_NOP = 14'h0000;
  localparam logic [13:0] W_RESET = 14'h0001;
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_RETURN_FROM_IRQ = 14'h0009;
  localparam logic [13:0] W_CALL_VIA_WREG = 14'h000a;
  localparam logic [13:0] W_BRW = 14'h000b;
  localparam logic [13:0] W_OPTION = 14'h0062;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_WATCHDOG_CLEAR_OP = 14'h0064;

  // Opcode prefixes, each compared against the top bits of the word.
  localparam logic [10:0] P_PIN_DIRECTION_REG = 11'h00c;
  localparam logic [10:0] P_INDIRECT_LOAD_WREG = 11'h002;
  localparam logic [10:0] P_INDIRECT_STORE_WREG = 11'h003;
  localparam logic [6:0] P_POINTER_ADD_LITERAL = 7'h62;
  localparam logic [6:0] P_MOVIWK = 7'h7e;
  localparam logic [6:0] P_MOVWIK = 7'h7f;
  localparam logic [4:0] P_BRA = 5'h19;
  localparam logic [2:0] P_CALL = 3'h4;
  localparam logic [2:0] P_JUMP_ABSOLUTE_OP = 3'h5;
  localparam logic [5:0] P_RETURN_WITH_LITERAL = 6'h34;
  localparam logic [5:0] P_AND_LITERAL_OP = 6'h39;
  localparam logic [5:0] P_ADD_LITERAL_OP = 6'h3e;
  localparam logic [5:0] P_ADD_WREG_FILE_OP = 6'h07;

  // Pointer modifier encodings and file addresses of the indirect ports.
  localparam logic [1:0] MM_PREINC = 2'h0;
  localparam logic [1:0] MM_PREDEC = 2'h1;
  localparam logic [1:0] MM_POSTINC = 2'h2;
  localparam logic [6:0] F_IND1 = 7'h01;
  localparam logic [6:0] F_IND_LIMIT = 7'h02;

  // Extra instruction cycles and reset values.
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PIN_DIRECTION_REG_RST = 8'hff;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRA = 5'h01, OP_BRW = 5'h02, OP_CALL = 5'h03,
    OP_CALL_VIA_WREG = 5'h04, OP_JUMP_ABSOLUTE_OP = 5'h05, OP_RETURN_FROM_IRQ = 5'h06, OP_RETURN_WITH_LITERAL = 5'h07,
    OP_RETURN = 5'h08, OP_WATCHDOG_CLEAR_OP = 5'h09, OP_OPTION = 5'h0a, OP_RESET = 5'h0b,
    OP_SLEEP = 5'h0c, OP_PIN_DIRECTION_REG = 5'h0d, OP_POINTER_ADD_LITERAL = 5'h0e, OP_INDIRECT_LOAD_WREG = 5'h0f,
    OP_MOVIWK = 5'h10, OP_INDIRECT_STORE_WREG = 5'h11, OP_MOVWIK = 5'h12, OP_AND_LITERAL_OP = 5'h13,
    OP_ADD_LITERAL_OP = 5'h14, OP_ADD_WREG_FILE_OP = 5'h15
  } eid_op_e;

  typedef enum logic {ST_RUN = 1'b0, ST_STALL = 1'b1} eid_st_e;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } eid_av_req_s;

  typedef struct packed {
    logic wdt_clear;
    logic standby;
    logic soft_reset;
  } eid_ev_s;

  typedef struct packed {
    logic [7:0] w;
    logic [1:0][15:0] fsr;
    logic [14:0] pc;
    logic [3:0] sp;
    logic [15:0][14:0] stack;
    logic [127:0][7:0] mem;
    logic [7:0] option;
    logic [7:0][7:0] pin_direction_reg;
    logic c, dc, z, pd, to, gie;
    logic [6:0] faddr;
    logic [1:0] wait_cnt;
    eid_st_e st;
    logic rd_done;
    logic [31:0] rdata;
    eid_ev_s ev;
  } eid_state_s;

  localparam eid_state_s STATE_RST = '{option: OPTION_RST, pin_direction_reg: {8{PIN_DIRECTION_REG_RST}},
    pd: 1'b1, to: 1'b1, st: ST_RUN, default: '0};

endpackage : eid_pkg
`default_nettype wire

// >>> src/eid_core.sv
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module eid_core (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire eid_pkg::eid_av_req_s avs_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output eid_pkg::eid_ev_s core_ev_o,
  output logic [7:0] option_o
);

  // Decoding is needed by the executor and by the checks below.
  function automatic eid_pkg::eid_op_e eid_decode(input logic [13:0] iw);
    eid_pkg::eid_op_e op;
    op = eid_pkg::OP_NOP;
    if (iw == eid_pkg::W_BRW) op = eid_pkg::OP_BRW;
    else if (iw == eid_pkg::W_CALL_VIA_WREG) op = eid_pkg::OP_CALL_VIA_WREG;
    else if (iw == eid_pkg::W_RETURN_FROM_IRQ) op = eid_pkg::OP_RETURN_FROM_IRQ;
    else if (iw == eid_pkg::W_RETURN) op = eid_pkg::OP_RETURN;
    else if (iw == eid_pkg::W_RESET) op = eid_pkg::OP_RESET;
    else if (iw == eid_pkg::W_WATCHDOG_CLEAR_OP) op = eid_pkg::OP_WATCHDOG_CLEAR_OP;
    else if (iw == eid_pkg::W_OPTION) op = eid_pkg::OP_OPTION;
    else if (iw == eid_pkg::W_SLEEP) op = eid_pkg::OP_SLEEP;
    else if (iw[13:3] == eid_pkg::P_PIN_DIRECTION_REG) op = eid_pkg::OP_PIN_DIRECTION_REG;
    else if (iw[13:3] == eid_pkg::P_INDIRECT_LOAD_WREG) op = eid_pkg::OP_INDIRECT_LOAD_WREG;
    else if (iw[13:3] == eid_pkg::P_INDIRECT_STORE_WREG) op = eid_pkg::OP_INDIRECT_STORE_WREG;
    else if (iw[13:7] == eid_pkg::P_POINTER_ADD_LITERAL) op = eid_pkg::OP_POINTER_ADD_LITERAL;
    else if (iw[13:7] == eid_pkg::P_MOVIWK) op = eid_pkg::OP_MOVIWK;
    else if (iw[13:7] == eid_pkg::P_MOVWIK) op = eid_pkg::OP_MOVWIK;
    else if (iw[13:9] == eid_pkg::P_BRA) op = eid_pkg::OP_BRA;
    else if (iw[13:11] == eid_pkg::P_CALL) op = eid_pkg::OP_CALL;
    else if (iw[13:11] == eid_pkg::P_JUMP_ABSOLUTE_OP) op = eid_pkg::OP_JUMP_ABSOLUTE_OP;
    else if (iw[13:8] == eid_pkg::P_RETURN_WITH_LITERAL) op = eid_pkg::OP_RETURN_WITH_LITERAL;
    else if (iw[13:8] == eid_pkg::P_AND_LITERAL_OP) op = eid_pkg::OP_AND_LITERAL_OP;
    else if (iw[13:8] == eid_pkg::P_ADD_LITERAL_OP) op = eid_pkg::OP_ADD_LITERAL_OP;
    else if (iw[13:8] == eid_pkg::P_ADD_WREG_FILE_OP) op = eid_pkg::OP_ADD_WREG_FILE_OP;
    return op;
  endfunction : eid_decode

  eid_pkg::eid_state_s s_q, s_d;
  logic [13:0] iw;
  eid_pkg::eid_op_e op;
  logic busy, rd_req, wr_acc, exec;
  logic ptr_n, mm_ptr_n, f_ind;
  logic [15:0] ptr_sel, mm_ptr_sel, ind_ptr, lit_addr, mm_step, mm_new, mm_addr;
  logic [6:0] fidx;
  logic [7:0] opnd;
  logic [8:0] sum9;
  logic [4:0] hsum5;
  logic [14:0] pc_inc, stack_top;

  // Operand steering for the current instruction word.
  assign iw = avs_i.writedata[13:0];
  assign op = eid_decode(iw);
  assign busy = (s_q.st == eid_pkg::ST_STALL);
  assign pc_inc = s_q.pc + 15'h0001;
  assign stack_top = s_q.stack[s_q.sp - 4'h1];
  assign ptr_n = iw[6];
  assign mm_ptr_n = iw[2];
  assign ptr_sel = s_q.fsr[ptr_n];
  assign mm_ptr_sel = s_q.fsr[mm_ptr_n];
  assign lit_addr = ptr_sel + {{10{iw[5]}}, iw[5:0]};
  assign mm_step = iw[0] ? 16'hffff : 16'h0001;
  assign mm_new = mm_ptr_sel + mm_step;
  assign mm_addr = iw[1] ? mm_ptr_sel : mm_new;
  // File addresses 0 and 1 are the indirect data ports of the two pointers.
  assign f_ind = (iw[6:0] < eid_pkg::F_IND_LIMIT);
  assign ind_ptr = s_q.fsr[iw[0]];
  assign fidx = f_ind ? ind_ptr[6:0] : iw[6:0];
  assign opnd = (op == eid_pkg::OP_ADD_WREG_FILE_OP) ? s_q.mem[fidx] : iw[7:0];
  assign sum9 = {1'b0, s_q.w} + {1'b0, opnd};
  assign hsum5 = {1'b0, s_q.w[3:0]} + {1'b0, opnd[3:0]};

  // Reads take one wait state so that readdata always comes from a flop.
  assign rd_req = avs_i.read;
  assign avs_waitrequest_o = !ce_i || (rd_req && !s_q.rd_done) ||
    (avs_i.write && (avs_i.address == eid_pkg::REG_INSTR) && busy);
  assign wr_acc = avs_i.write && !avs_waitrequest_o;
  assign exec = wr_acc && (avs_i.address == eid_pkg::REG_INSTR);
  assign avs_readdata_o = s_q.rdata;
  assign core_ev_o = s_q.ev;
  assign option_o = s_q.option;

  // Next state: read capture, stall countdown, register writes, execution.
  always_comb begin
    s_d = s_q;
    s_d.ev = '0;
    s_d.rd_done = rd_req && !s_q.rd_done;
    if (rd_req && !s_q.rd_done) begin
      s_d.rdata = '0;
      unique case (avs_i.address)
        eid_pkg::REG_WREG: s_d.rdata[7:0] = s_q.w;
        eid_pkg::REG_STATUS: begin
          s_d.rdata[eid_pkg::ST_C] = s_q.c;
          s_d.rdata[eid_pkg::ST_DC] = s_q.dc;
          s_d.rdata[eid_pkg::ST_Z] = s_q.z;
          s_d.rdata[eid_pkg::ST_PD] = s_q.pd;
          s_d.rdata[eid_pkg::ST_TO] = s_q.to;
          s_d.rdata[eid_pkg::ST_GIE] = s_q.gie;
          s_d.rdata[eid_pkg::ST_BUSY] = busy;
        end
        eid_pkg::REG_FSR0: s_d.rdata[15:0] = s_q.fsr[0];
        eid_pkg::REG_FSR1: s_d.rdata[15:0] = s_q.fsr[1];
        eid_pkg::REG_PC: s_d.rdata[14:0] = s_q.pc;
        eid_pkg::REG_OPTION: s_d.rdata[7:0] = s_q.option;
        eid_pkg::REG_PINDIR: s_d.rdata[7:0] = s_q.pin_direction_reg[s_q.faddr[2:0]];
        eid_pkg::REG_FADDR: s_d.rdata[6:0] = s_q.faddr;
        eid_pkg::REG_FDATA: s_d.rdata[7:0] = s_q.mem[s_q.faddr];
        default: s_d.rdata = '0;
      endcase
    end
    // The idle second cycle of a long instruction runs here as a no-op.
    if (busy) begin
      s_d.wait_cnt = s_q.wait_cnt - 2'h1;
      if (s_q.wait_cnt == eid_pkg::EXTRA_ONE) begin
        s_d.st = eid_pkg::ST_RUN;
      end
    end
    if (wr_acc) begin
      unique case (avs_i.address)
        eid_pkg::REG_WREG: s_d.w = avs_i.writedata[7:0];
        eid_pkg::REG_FSR0: s_d.fsr[0] = avs_i.writedata[15:0];
        eid_pkg::REG_FSR1: s_d.fsr[1] = avs_i.writedata[15:0];
        eid_pkg::REG_PC: s_d.pc = avs_i.writedata[14:0];
        eid_pkg::REG_FADDR: s_d.faddr = avs_i.writedata[6:0];
        eid_pkg::REG_FDATA: s_d.mem[s_q.faddr] = avs_i.writedata[7:0];
        default: ;
      endcase
    end
    if (exec) begin
      s_d.pc = pc_inc;
      s_d.wait_cnt = eid_pkg::EXTRA_NONE;
      unique case (op)
        eid_pkg::OP_BRA: begin
          s_d.pc = pc_inc + {{6{iw[8]}}, iw[8:0]};
          s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_BRW: begin
          s_d.pc = pc_inc + {7'h00, s_q.w};
          s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_CALL, eid_pkg::OP_CALL_VIA_WREG: begin
          s_d.stack[s_q.sp] = pc_inc;
          s_d.sp = s_q.sp + 4'h1;
          if (op == eid_pkg::OP_CALL) begin
            s_d.pc = {s_q.pc[14:11], iw[10:0]};
          end else begin
            s_d.pc = {s_q.pc[14:8], s_q.w};
          end
          s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_JUMP_ABSOLUTE_OP: begin
          s_d.pc = {s_q.pc[14:11], iw[10:0]};
          s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_RETURN_FROM_IRQ, eid_pkg::OP_RETURN_WITH_LITERAL, eid_pkg::OP_RETURN: begin
          s_d.pc = stack_top;
          s_d.sp = s_q.sp - 4'h1;
          s_d.wait_cnt = eid_pkg::EXTRA_ONE;
          if (op == eid_pkg::OP_RETURN_FROM_IRQ) s_d.gie = 1'b1;
          if (op == eid_pkg::OP_RETURN_WITH_LITERAL) s_d.w = iw[7:0];
        end
        eid_pkg::OP_WATCHDOG_CLEAR_OP: begin
          s_d.to = 1'b1;
          s_d.pd = 1'b1;
          s_d.ev.wdt_clear = 1'b1;
        end
        eid_pkg::OP_OPTION: s_d.option = s_q.w;
        eid_pkg::OP_RESET: begin
          // Data memory survives a software reset, as it would in silicon.
          s_d = eid_pkg::STATE_RST;
          s_d.mem = s_q.mem;
          s_d.ev.soft_reset = 1'b1;
        end
        eid_pkg::OP_SLEEP: begin
          s_d.to = 1'b1;
          s_d.pd = 1'b0;
          s_d.ev.standby = 1'b1;
        end
        eid_pkg::OP_PIN_DIRECTION_REG: s_d.pin_direction_reg[iw[2:0]] = s_q.w;
        eid_pkg::OP_POINTER_ADD_LITERAL: s_d.fsr[ptr_n] = lit_addr;
        eid_pkg::OP_INDIRECT_LOAD_WREG, eid_pkg::OP_INDIRECT_STORE_WREG: begin
          s_d.fsr[mm_ptr_n] = mm_new;
          if (op == eid_pkg::OP_INDIRECT_LOAD_WREG) begin
            s_d.w = s_q.mem[mm_addr[6:0]];
            s_d.z = (s_q.mem[mm_addr[6:0]] == 8'h00);
          end else begin
            s_d.mem[mm_addr[6:0]] = s_q.w;
          end
          if (mm_addr[15]) s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_MOVIWK, eid_pkg::OP_MOVWIK: begin
          if (op == eid_pkg::OP_MOVIWK) begin
            s_d.w = s_q.mem[lit_addr[6:0]];
            s_d.z = (s_q.mem[lit_addr[6:0]] == 8'h00);
          end else begin
            s_d.mem[lit_addr[6:0]] = s_q.w;
          end
          if (lit_addr[15]) s_d.wait_cnt = eid_pkg::EXTRA_ONE;
        end
        eid_pkg::OP_AND_LITERAL_OP: begin
          s_d.w = s_q.w & iw[7:0];
          s_d.z = ((s_q.w & iw[7:0]) == 8'h00);
        end
        eid_pkg::OP_ADD_LITERAL_OP, eid_pkg::OP_ADD_WREG_FILE_OP: begin
          s_d.c = sum9[8];
          s_d.dc = hsum5[4];
          s_d.z = (sum9[7:0] == 8'h00);
          if ((op == eid_pkg::OP_ADD_WREG_FILE_OP) && iw[7]) begin
            s_d.mem[fidx] = sum9[7:0];
          end else begin
            s_d.w = sum9[7:0];
          end
          if ((op == eid_pkg::OP_ADD_WREG_FILE_OP) && f_ind && ind_ptr[15]) begin
            s_d.wait_cnt = eid_pkg::EXTRA_ONE;
          end
        end
        default: ;
      endcase
      if (s_d.wait_cnt != eid_pkg::EXTRA_NONE) s_d.st = eid_pkg::ST_STALL;
    end
  end

  // One register stage for all state; the clock enable freezes everything.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= eid_pkg::STATE_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Checks on the executor; helper signals hold the expected results.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic [14:0] brw_tgt;
  logic [15:0] pointer_add_literal_exp;
  logic [7:0] and_exp;
  assign brw_tgt = pc_inc + {7'h00, s_q.w};
  assign pointer_add_literal_exp = ptr_sel + {{10{iw[5]}}, iw[5:0]};
  assign and_exp = s_q.w & iw[7:0];

  property p_branch_stall;
    exec && (op inside {eid_pkg::OP_BRA, eid_pkg::OP_JUMP_ABSOLUTE_OP, eid_pkg::OP_CALL})
      |=> busy && (s_q.wait_cnt == 2'h1);
  endproperty
  a_branch_stall: assert property (p_branch_stall) else $error("branch without stall");

  property p_ind_stall;
    exec && (op == eid_pkg::OP_MOVIWK) && lit_addr[15] |=> busy;
  endproperty
  a_ind_stall: assert property (p_ind_stall) else $error("indirect extra cycle missing");

  property p_brw;
    exec && (op == eid_pkg::OP_BRW) |=> (s_q.pc == $past(brw_tgt)) && busy;
  endproperty
  a_brw: assert property (p_brw) else $error("relative branch target wrong");

  property p_return;
    exec && (op == eid_pkg::OP_RETURN)
      |=> (s_q.pc == $past(stack_top)) && (s_q.sp == $past(s_q.sp) - 4'h1);
  endproperty
  a_return: assert property (p_return) else $error("return target wrong");

  property p_return_with_literal;
    exec && (op == eid_pkg::OP_RETURN_WITH_LITERAL) |=> s_q.w == $past(iw[7:0]);
  endproperty
  a_return_with_literal: assert property (p_return_with_literal) else $error("return literal lost");

  property p_watchdog_clear_op;
    exec && (op == eid_pkg::OP_WATCHDOG_CLEAR_OP) |=> s_q.to && s_q.pd && core_ev_o.wdt_clear && !busy;
  endproperty
  a_watchdog_clear_op: assert property (p_watchdog_clear_op) else $error("watchdog clear wrong");

  property p_sleep;
    exec && (op == eid_pkg::OP_SLEEP) |=> s_q.to && !s_q.pd && core_ev_o.standby;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby flags wrong");

  property p_pointer_add_literal;
    exec && (op == eid_pkg::OP_POINTER_ADD_LITERAL) && !ptr_n
      |=> (s_q.fsr[0] == $past(pointer_add_literal_exp)) && $stable(s_q.z) && $stable(s_q.c);
  endproperty
  a_pointer_add_literal: assert property (p_pointer_add_literal) else $error("pointer add wrong");

  property p_and_literal_op;
    exec && (op == eid_pkg::OP_AND_LITERAL_OP)
      |=> (s_q.w == $past(and_exp)) && (s_q.z == (s_q.w == 8'h00)) && $stable(s_q.c);
  endproperty
  a_and_literal_op: assert property (p_and_literal_op) else $error("literal and wrong");

  property p_add_literal_op;
    exec && (op == eid_pkg::OP_ADD_LITERAL_OP) |=> {s_q.c, s_q.w} == $past(sum9);
  endproperty
  a_add_literal_op: assert property (p_add_literal_op) else $error("literal add wrong");

  property p_reset_op;
    exec && (op == eid_pkg::OP_RESET) |=> core_ev_o.soft_reset && (s_q.pc == 15'h0000);
  endproperty
  a_reset_op: assert property (p_reset_op) else $error("software reset missed");

  property p_instr_hold;
    busy && avs_i.write && (avs_i.address == eid_pkg::REG_INSTR) |-> avs_waitrequest_o;
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("instruction taken while busy");

  // A long instruction idles for exactly one enabled cycle, never more.
  property p_one_idle;
    busy && ce_i |=> !busy;
  endproperty
  a_one_idle: assert property (p_one_idle) else $error("idle cycle count wrong");

  c_call: cover property (exec && (op == eid_pkg::OP_CALL));
  c_ind_stall: cover property (exec && (op == eid_pkg::OP_INDIRECT_STORE_WREG) && mm_addr[15]);
  c_add_wreg_file_op_file: cover property (exec && (op == eid_pkg::OP_ADD_WREG_FILE_OP) && iw[7]);
  c_busy_write: cover property (busy && avs_i.write && avs_waitrequest_o);

endmodule : eid_core
`default_nettype wire

// >>> dv/eid_host.sv
`timescale 1ns/10ps
`default_nettype none
// Register bus master that stands in for the software side of the core.
module eid_host (
  input wire logic mclk_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  output var eid_pkg::eid_av_req_s avs_o
);

  // The bus is quiet from time zero.
  initial begin
    avs_o = '0;
  end

  // The answer is taken at the rising edge itself, before that edge's flops update.
  // The request stays up after the accepting edge, so back-to-back calls are legal.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output int waits);
    int n;
    n = 0;
    avs_o <= '{address: addr, read: !wr, write: wr, writedata: wdata};
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_i !== 1'b0);
    rdata = avs_readdata_i;
    waits = n - 1;
  endtask : xfer

  // Drops the request; called only right after an accepting edge.
  task automatic idle();
    avs_o <= '0;
  endtask : idle
endmodule : eid_host
`default_nettype wire

// >>> dv/enhanced_instr_decode_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module enhanced_instr_decode_ctrl_tb;
  typedef struct packed {
    logic [7:0] w;
    logic [13:0] op;
    logic [7:0] w_exp;
    logic [2:0] fl;
    logic [1:0] wt;
  } eid_row_s;

  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  eid_pkg::eid_av_req_s avs;
  eid_pkg::eid_ev_s ev;
  logic [31:0] rdata_w;
  logic wreq;
  logic [7:0] opt;
  logic [31:0] rd;
  int wt;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_stby = 0;
  int n_wdt = 0;
  int n_rst = 0;

  // Literal rows; flags are {zero, digit carry, carry} and carry over from row to row.
  eid_row_s rows [6] = '{
    '{8'h0f, {eid_pkg::P_ADD_LITERAL_OP, 8'h01}, 8'h10, 3'h2, 2'h0},
    '{8'hff, {eid_pkg::P_ADD_LITERAL_OP, 8'h01}, 8'h00, 3'h7, 2'h0},
    '{8'hf0, {eid_pkg::P_AND_LITERAL_OP, 8'h0f}, 8'h00, 3'h7, 2'h0},
    '{8'hf0, {eid_pkg::P_AND_LITERAL_OP, 8'h3c}, 8'h30, 3'h3, 2'h0},
    '{8'h80, {eid_pkg::P_ADD_LITERAL_OP, 8'h80}, 8'h00, 3'h5, 2'h0},
    '{8'h00, {eid_pkg::P_RETURN_WITH_LITERAL, 8'h5a}, 8'h5a, 3'h5, 2'h1}};

  eid_core dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .avs_i(avs),
    .avs_readdata_o(rdata_w), .avs_waitrequest_o(wreq), .core_ev_o(ev), .option_o(opt));

  eid_host host (.mclk_i(mclk_i), .avs_readdata_i(rdata_w), .avs_waitrequest_i(wreq),
    .avs_o(avs));

  // Free-running clock and a cycle ceiling well above the expected run length.
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    n_stby += (ev.standby === 1'b1);
    n_wdt += (ev.wdt_clear === 1'b1);
    n_rst += (ev.soft_reset === 1'b1);
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, wt);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd, wt);
    chk(rd & m, e);
  endtask : rdm

  // Runs one word, then a second word straight after; its stall counts the idle cycles.
  task automatic exec(input logic [13:0] op, input int ew);
    wr(eid_pkg::REG_INSTR, {18'h0, op});
    wr(eid_pkg::REG_INSTR, {18'h0, eid_pkg::W_NOP});
    chk(wt, ew);
  endtask : exec

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      wr(eid_pkg::REG_WREG, {24'h0, rows[i].w});
      exec(rows[i].op, int'(rows[i].wt));
      rdm(eid_pkg::REG_WREG, 32'hff, {24'h0, rows[i].w_exp});
      rdm(eid_pkg::REG_STATUS, 32'h7, {29'h0, rows[i].fl});
    end
    done("literal rows");
    // A second reset in mid-run must bring back the reset values of W, status and option.
    host.idle();
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rdm(eid_pkg::REG_WREG, 32'hffffffff, 32'h0);
    rdm(eid_pkg::REG_STATUS, 32'hffffffff, 32'h18);
    rdm(eid_pkg::REG_OPTION, 32'hffffffff, 32'hff);
    rdm(8'h30, 32'hffffffff, 32'h0);
    wr(eid_pkg::REG_STATUS, 32'h7);
    rdm(eid_pkg::REG_STATUS, 32'hffffffff, 32'h18);
    done("reset");
    wr(eid_pkg::REG_FSR0, 32'hffff);
    exec({eid_pkg::P_POINTER_ADD_LITERAL, 1'b0, 6'h01}, 0);
    rdm(eid_pkg::REG_FSR0, 32'hffffffff, 32'h0);
    exec({eid_pkg::P_POINTER_ADD_LITERAL, 1'b1, 6'h3f}, 0);
    rdm(eid_pkg::REG_FSR1, 32'hffffffff, 32'hffff);
    rdm(eid_pkg::REG_STATUS, 32'h7, 32'h0);
    done("pointer add");
    wr(eid_pkg::REG_FSR1, 32'h10);
    wr(eid_pkg::REG_WREG, 32'ha5);
    exec({eid_pkg::P_INDIRECT_STORE_WREG, 1'b1, eid_pkg::MM_PREINC}, 0);
    rdm(eid_pkg::REG_FSR1, 32'hffffffff, 32'h11);
    wr(eid_pkg::REG_WREG, 32'h0);
    exec({eid_pkg::P_INDIRECT_LOAD_WREG, 1'b1, 2'h3}, 0);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'ha5);
    rdm(eid_pkg::REG_FSR1, 32'hffffffff, 32'h10);
    rdm(eid_pkg::REG_STATUS, 32'h7, 32'h0);
    wr(eid_pkg::REG_WREG, 32'h5c);
    exec({eid_pkg::P_INDIRECT_STORE_WREG, 1'b1, eid_pkg::MM_PREDEC}, 0);
    wr(eid_pkg::REG_WREG, 32'h0);
    exec({eid_pkg::P_INDIRECT_LOAD_WREG, 1'b1, eid_pkg::MM_POSTINC}, 0);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'h5c);
    rdm(eid_pkg::REG_FSR1, 32'hffffffff, 32'h10);
    wr(eid_pkg::REG_FADDR, 32'h11);
    rdm(eid_pkg::REG_FDATA, 32'hff, 32'ha5);
    wr(eid_pkg::REG_FADDR, 32'h1f);
    wr(eid_pkg::REG_FDATA, 32'h77);
    wr(eid_pkg::REG_FSR0, 32'h20);
    wr(eid_pkg::REG_WREG, 32'h0);
    exec({eid_pkg::P_MOVWIK, 1'b0, 6'h3f}, 0);
    rdm(eid_pkg::REG_FDATA, 32'hff, 32'h0);
    wr(eid_pkg::REG_WREG, 32'h33);
    exec({eid_pkg::P_MOVIWK, 1'b0, 6'h3f}, 0);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'h0);
    rdm(eid_pkg::REG_STATUS, 32'h4, 32'h4);
    wr(eid_pkg::REG_FSR0, 32'h8000);
    exec({eid_pkg::P_MOVIWK, 1'b0, 6'h00}, 1);
    done("indirect");
    wr(eid_pkg::REG_FADDR, 32'h30);
    wr(eid_pkg::REG_FDATA, 32'h10);
    wr(eid_pkg::REG_WREG, 32'h05);
    exec({eid_pkg::P_ADD_WREG_FILE_OP, 1'b0, 7'h30}, 0);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'h15);
    exec({eid_pkg::P_ADD_WREG_FILE_OP, 1'b1, 7'h30}, 0);
    rdm(eid_pkg::REG_FDATA, 32'hff, 32'h25);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'h15);
    // File address 0 goes through the first pointer, whose top bit is still set.
    exec({eid_pkg::P_ADD_WREG_FILE_OP, 1'b0, 7'h00}, 1);
    rdm(eid_pkg::REG_WREG, 32'hff, 32'h15);
    done("register add");
    // Each program counter check allows for the trailing word that exec runs.
    wr(eid_pkg::REG_WREG, 32'h05);
    wr(eid_pkg::REG_PC, 32'h100);
    exec(eid_pkg::W_BRW, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h107);
    exec({eid_pkg::P_BRA, 9'h1f0}, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'hf9);
    wr(eid_pkg::REG_PC, 32'h4100);
    exec({eid_pkg::P_JUMP_ABSOLUTE_OP, 11'h234}, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h4235);
    exec({eid_pkg::P_CALL, 11'h055}, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h4056);
    wr(eid_pkg::REG_WREG, 32'h77);
    exec(eid_pkg::W_CALL_VIA_WREG, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h4078);
    exec(eid_pkg::W_RETURN, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h4058);
    exec(eid_pkg::W_RETURN_FROM_IRQ, 1);
    rdm(eid_pkg::REG_PC, 32'hffffffff, 32'h4237);
    rdm(eid_pkg::REG_STATUS, 32'h20, 32'h20);
    done("control");
    wr(eid_pkg::REG_WREG, 32'h3c);
    exec(eid_pkg::W_OPTION, 0);
    chk({24'h0, opt}, 32'h3c);
    rdm(eid_pkg::REG_OPTION, 32'hffffffff, 32'h3c);
    wr(eid_pkg::REG_WREG, 32'h12);
    exec({eid_pkg::P_PIN_DIRECTION_REG, 3'h5}, 0);
    wr(eid_pkg::REG_WREG, 32'h34);
    exec({eid_pkg::P_PIN_DIRECTION_REG, 3'h7}, 0);
    wr(eid_pkg::REG_FADDR, 32'h5);
    rdm(eid_pkg::REG_PINDIR, 32'hffffffff, 32'h12);
    wr(eid_pkg::REG_FADDR, 32'h7);
    rdm(eid_pkg::REG_PINDIR, 32'hffffffff, 32'h34);
    wr(eid_pkg::REG_FADDR, 32'h6);
    rdm(eid_pkg::REG_PINDIR, 32'hffffffff, 32'hff);
    exec(eid_pkg::W_SLEEP, 0);
    rdm(eid_pkg::REG_STATUS, 32'h18, 32'h10);
    chk(n_stby, 1);
    exec(eid_pkg::W_WATCHDOG_CLEAR_OP, 0);
    rdm(eid_pkg::REG_STATUS, 32'h18, 32'h18);
    chk(n_wdt, 1);
    exec(eid_pkg::W_RESET, 0);
    chk({24'h0, opt}, 32'hff);
    rdm(eid_pkg::REG_WREG, 32'hffffffff, 32'h0);
    rdm(eid_pkg::REG_FSR0, 32'hffffffff, 32'h0);
    chk(n_rst, 1);
    wr(eid_pkg::REG_FADDR, 32'h11);
    rdm(eid_pkg::REG_FDATA, 32'hff, 32'ha5);
    done("inherent");
    // With the clock enable low the bus must stall every request.
    ce_i <= 1'b0;
    @(negedge mclk_i);
    chk({31'h0, wreq}, 32'h1);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rdm(eid_pkg::REG_WREG, 32'hffffffff, 32'h0);
    done("clock enable");
    finish_test();
  end
endmodule : enhanced_instr_decode_ctrl_tb
`default_nettype wire
